// ==== sim/vertical_sequence_parameters_test.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module vertical_sequence_parameters_test;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [25:0] wdata = 26'h0;
  logic bnd = 1'b0;
  logic [25:0] rdata;
  logic [12:0] pat_a, pat_b, vout, a_pos, b_pos;
  logic [4:0] a_sel, b_sel;
  logic blank, odd;
  logic [25:0] cfg [10];
  logic [25:0] rv;
  int n_errors = 0;
  int n_checks = 0;
  int cv [4];
  int cb [4];
  int cycles = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  vsq_top dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd_s),
    .reg_addr_i(addr), .reg_data_i(wdata), .reg_rdata_o(rdata),
    .sequence_change_boundary_i(bnd), .pat_a_level_i(pat_a),
    .pat_b_level_i(pat_b), .vert_out_o(vout), .horizontal_blanking_o(blank),
    .group_a_pattern_choice_o(a_sel), .group_b_pattern_choice_o(b_sel),
    .group_a_pos_o(a_pos), .group_b_pos_o(b_pos), .line_odd_o(odd)
  );

  vsq_pattern_src src_u (
    .a_choice_i(a_sel), .b_choice_i(b_sel), .a_pos_i(a_pos),
    .b_pos_i(b_pos), .a_level_o(pat_a), .b_level_o(pat_b)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard; the full run needs well under a tenth of this
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic wr_reg(input logic [3:0] a, input logic [25:0] d);
    @(negedge clk_sys_i);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk_sys_i);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [25:0] d);
    @(negedge clk_sys_i);
    rd_s = 1'b1;
    addr = a;
    @(negedge clk_sys_i);
    rd_s = 1'b0;
    @(negedge clk_sys_i);
    d = rdata;
  endtask

  task automatic load();
    for (int a = 0; a < 10; a++) begin
      wr_reg(4'(a), cfg[a]);
    end
  endtask

  // Boundary pulse, then count four 20-pixel lines of activity
  task automatic run(input logic [12:0] w);
    @(negedge clk_sys_i);
    bnd = 1'b1;
    @(negedge clk_sys_i);
    bnd = 1'b0;
    for (int k = 0; k < 4; k++) begin
      cv[k] = 0;
      cb[k] = 0;
    end
    for (int i = 0; i < 80; i++) begin
      if (vout === w) cv[i / 20]++;
      if (blank === 1'b1) cb[i / 20]++;
      if (i % 20 == 10) `CHK(odd, 1'((i / 20) % 2 == 0))
      @(negedge clk_sys_i);
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'b0;
    for (int a = 0; a < 11; a++) begin
      rd_reg(4'(a), rv);
      `CHK(rv, 26'h0)
    end
    for (int a = 0; a < 10; a++) begin
      cfg[a] = 26'h3000000 | 26'(a * 26'h0041041);
    end
    load();
    wr_reg(4'ha, 26'h3ffffff);
    for (int a = 0; a < 11; a++) begin
      rd_reg(4'(a), rv);
      `CHK(rv, (a < 10) ? cfg[a] : 26'h0)
    end
    `CHK(a_sel, 5'h0)
    // Run's line-parity check needs 20-pixel lines
    wr_reg(4'h0, {13'd20, 13'h0});
    run(13'h0);
    `CHK(a_sel, cfg[2][23:19])
    `CHK(b_sel, cfg[2][18:14])
    $display("test registers done");

    cfg[0] = {13'd20, 13'h0};
    cfg[1] = 26'h0;
    cfg[3] = {13'd2, 13'd3};
    cfg[4] = {13'd3, 13'd2};
    cfg[5] = 26'h0;
    cfg[6] = {1'b0, 12'd2, 1'b0, 12'd1};
    cfg[7] = {13'd4, 13'd3};
    cfg[8] = {13'd7, 13'd3};
    cfg[9] = 26'h3ffffff;
    for (int m = 0; m < 4; m++) begin
      cfg[2] = {2'(m), 5'd1, 5'd3, 1'b0, 13'h0001};
      load();
      run(13'h1ffe);
      for (int k = 0; k < 4; k++) begin
        `CHK(cv[k], 3 * (k % (m + 1) + 1))
      end
    end
    $display("test group a done");

    cfg[2] = {2'd0, 5'd1, 5'd3, 1'b0, 13'h1fff};
    cfg[5] = {1'b0, 12'd1, 1'b0, 12'd4};
    load();
    run(13'h1fff);
    for (int k = 0; k < 4; k++) begin
      `CHK(cv[k], (k % 2 == 0) ? 8 : 2)
    end
    cfg[2] = {2'd0, 5'd1, 5'd3, 1'b1, 13'h0};
    load();
    run(13'h1fff);
    for (int k = 0; k < 4; k++) begin
      `CHK(cv[k], (k % 2 == 0) ? 7 : 1)
    end
    $display("test group b done");

    cfg[2] = {2'd0, 5'd1, 5'd3, 1'b0, 13'h0};
    cfg[5] = 26'h0;
    cfg[9] = {13'd15, 13'd14};
    for (int m = 0; m < 4; m++) begin
      cfg[0] = {13'd20, 8'h0, 2'(m), 3'h0};
      load();
      run(13'h1fff);
      `CHK(cv[0], m[0] ? 7 : 3)
      `CHK(cb[0], 0)
    end
    $display("test hold done");

    cfg[7] = {13'd6, 13'd3};
    cfg[8] = {13'd12, 13'd10};
    for (int h = 1; h < 8; h++) begin
      cfg[0] = {13'd20, 5'h0, 3'(h), 2'd3, 3'h0};
      load();
      run(13'h1fff);
      for (int k = 0; k < 4; k++) begin
        `CHK(cb[k], (k % 2 == 0) ? 6 : 0)
      end
    end
    $display("test blanking done");
    print_verdict();
  end
endmodule

// ==== sim/vsq_pattern_src.sv ====
`timescale 1ns/100ps
module vsq_pattern_src #(
  parameter int NCH = vsq_pkg::VSQ_NCH
) (
  input wire logic [4:0] a_choice_i, // Group A pattern number
  input wire logic [4:0] b_choice_i, // Group B pattern number
  input wire logic [12:0] a_pos_i,   // Group A position
  input wire logic [12:0] b_pos_i,   // Group B position
  output logic [NCH-1:0] a_level_o,  // Group A levels
  output logic [NCH-1:0] b_level_o   // Group B levels
);
  // Odd patterns stay high so play time can be counted at the outputs;
  // even patterns give a stripe that follows the position
  always_comb begin
    a_level_o = a_choice_i[0] ? '1 : a_pos_i[NCH-1:0];
    b_level_o = b_choice_i[0] ? '1 : ~b_pos_i[NCH-1:0];
  end
endmodule

// ==== src/vsq_core_if.sv ====
`timescale 1ns/100ps
interface vsq_core_if;
  logic wr_en;
  logic rd_en;
  logic [vsq_pkg::VSQ_AW-1:0] wr_addr;
  logic [vsq_pkg::VSQ_AW-1:0] rd_addr;
  logic [vsq_pkg::VSQ_DW-1:0] wr_data;
  logic [vsq_pkg::VSQ_DW-1:0] rd_data;
  logic commit;
  logic [vsq_pkg::VSQ_NREG-1:0][vsq_pkg::VSQ_DW-1:0] word;
  logic [vsq_pkg::VSQ_PW-1:0] line_len;
  logic [1:0] alt_mode;
  logic [vsq_pkg::VSQ_PW-1:0] pix;
  logic line_last;
  logic line_odd;
  logic [1:0] phase;
  modport store(input wr_en, rd_en, wr_addr, rd_addr, wr_data, commit,
    output rd_data, word);
  modport timer(input line_len, alt_mode, commit,
    output pix, line_last, line_odd, phase);
  modport core(output wr_en, rd_en, wr_addr, rd_addr, wr_data, commit,
    line_len, alt_mode,
    input rd_data, word, pix, line_last, line_odd, phase);
endinterface

// ==== src/vsq_line_timer.sv ====
`timescale 1ns/100ps
module vsq_line_timer (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i,     // Async reset
  vsq_core_if.timer tm        // Pixel and line position
);
  assign tm.line_last = (tm.pix == tm.line_len - vsq_pkg::VSQ_ONE_POS);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tm.pix <= '0;
    end else if (tm.commit || tm.line_last) begin
      tm.pix <= '0;
    end else begin
      tm.pix <= tm.pix + vsq_pkg::VSQ_ONE_POS;
    end
  end

  // First line of a sequence counts as odd
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tm.line_odd <= 1'b1;
      tm.phase <= vsq_pkg::VSQ_PHASE0;
    end else if (tm.commit) begin
      tm.line_odd <= 1'b1;
      tm.phase <= vsq_pkg::VSQ_PHASE0;
    end else if (tm.line_last) begin
      tm.line_odd <= ~tm.line_odd;
      tm.phase <= (tm.phase >= tm.alt_mode) ? vsq_pkg::VSQ_PHASE0
                                            : tm.phase + vsq_pkg::VSQ_ONE_PHASE;
    end
  end
endmodule

// ==== src/vsq_param_store.sv ====
`timescale 1ns/100ps
module vsq_param_store #(
  parameter int NREG = vsq_pkg::VSQ_NREG
) (
  input wire logic clk_sys_i, // System clock
  input wire logic rst_i,     // Async reset
  vsq_core_if.store st        // Shadow and active words
);
  logic [vsq_pkg::VSQ_DW-1:0] shadow [NREG];

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NREG; i++) begin
        shadow[i] <= vsq_pkg::VSQ_RESET_WORD;
      end
    end else if (st.wr_en && int'(st.wr_addr) < NREG) begin
      shadow[st.wr_addr] <= st.wr_data;
    end
  end

  // Active copy only moves at a boundary
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NREG; i++) begin
        st.word[i] <= vsq_pkg::VSQ_RESET_WORD;
      end
    end else if (st.commit) begin
      for (int i = 0; i < NREG; i++) begin
        st.word[i] <= shadow[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st.rd_data <= vsq_pkg::VSQ_RESET_WORD;
    end else if (st.rd_en) begin
      st.rd_data <= (int'(st.rd_addr) < NREG) ? shadow[st.rd_addr]
                                               : vsq_pkg::VSQ_RESET_WORD;
    end
  end
endmodule

// ==== src/vsq_pkg.sv ====
package vsq_pkg;
  localparam int VSQ_DW = 26;
  localparam int VSQ_AW = 4;
  localparam int VSQ_NREG = 10;
  localparam int VSQ_PW = 13;
  localparam int VSQ_NCH = 13;
  localparam int VSQ_SELW = 5;
  localparam int VSQ_NTOG = 6;
  // Register indexes
  localparam int VSQ_LINE_REG = 0;
  localparam int VSQ_POL_REG = 1;
  localparam int VSQ_GSEL_REG = 2;
  localparam int VSQ_B_POS_REG = 3;
  localparam int VSQ_A_POS_REG = 4;
  localparam int VSQ_B_REP_REG = 5;
  localparam int VSQ_A_REP12_REG = 6;
  localparam int VSQ_A_REP34_REG = 7;
  localparam int VSQ_HOLD1_REG = 8;
  localparam int VSQ_HOLD2_REG = 9;
  // Field positions
  localparam int VSQ_LO_LSB = 0;
  localparam int VSQ_HI_LSB = 13;
  localparam int VSQ_REPW = 12;
  localparam int VSQ_MASK_LSB = 3;
  localparam int VSQ_ALT_LSB = 5;
  localparam int VSQ_ALTW = 3;
  localparam int VSQ_JOIN_BIT = 13;
  localparam int VSQ_PATB_LSB = 14;
  localparam int VSQ_PATA_LSB = 19;
  localparam int VSQ_AMODE_LSB = 24;
  localparam logic [25:0] VSQ_RESET_WORD = 26'h0000000;
  localparam logic [12:0] VSQ_ONE_POS = 13'h0001;
  localparam logic [1:0] VSQ_PHASE0 = 2'h0;
  localparam logic [1:0] VSQ_ONE_PHASE = 2'h1;
  typedef enum logic [1:0] {
    VSQ_MASK_OFF, VSQ_MASK_FIRST, VSQ_MASK_SECOND, VSQ_MASK_BOTH
  } vsq_mask_type;
  typedef enum logic [1:0] {VSQ_RUN, VSQ_HOLD1, VSQ_HOLD2} vsq_run_type;
  typedef enum logic [1:0] {VSQ_WAIT, VSQ_PLAY, VSQ_DONE} vsq_grp_type;
endpackage

// ==== src/vsq_top.sv ====
`timescale 1ns/100ps
// Behaviour
// - Mask field: 0 none, 1 first pair, 2 second pair, 3 both pairs.
// - At an enabled hold position all thirteen vertical outputs keep level.
// - At the matching restart position outputs resume and finish the pattern.
// - Nonzero three-bit field enables blanking alternation, reusing fields.
// - Group A third and fourth counts become odd-line blanking toggles 1-2.
// - Hold1, restart1, hold2, restart2 become odd-line blanking toggles 3-6.
// - Line length field sets pixels per line.
// - Per-channel choice bit selects group A (0) or group B (1).
// - Combine bit merges both groups' toggles into one pattern.
// - Five-bit field picks the group B pattern.
// - Five-bit field picks the group A pattern.
// - Alternation field cycles group A counts over 1 to 4 lines.
// - Group B has a start position and a length.
// - Group A has a start position and a length.
// - Group B repeats by odd-line or even-line count.
// - Group A repeats by first to fourth line count.
module vsq_top #(
  parameter int NCH = vsq_pkg::VSQ_NCH
) (
  input wire logic clk_sys_i,                 // 200 MHz clock
  input wire logic rst_i,                     // Async reset, high
  input wire logic reg_wr_i,                  // Register write strobe
  input wire logic reg_rd_i,                  // Register read strobe
  input wire logic [3:0] reg_addr_i,          // Register index
  input wire logic [25:0] reg_data_i,         // Write data
  output logic [25:0] reg_rdata_o,            // Read data
  input wire logic sequence_change_boundary_i, // Boundary pulse
  input wire logic [NCH-1:0] pat_a_level_i,   // Group A pattern levels
  input wire logic [NCH-1:0] pat_b_level_i,   // Group B pattern levels
  output logic [NCH-1:0] vert_out_o,          // Vertical outputs
  output logic horizontal_blanking_o,         // Blanking output
  output logic [4:0] group_a_pattern_choice_o, // Group A pattern
  output logic [4:0] group_b_pattern_choice_o, // Group B pattern
  output logic [12:0] group_a_pos_o,          // Position in A pattern
  output logic [12:0] group_b_pos_o,          // Position in B pattern
  output logic line_odd_o                     // Current line is odd
);
  localparam int PW = vsq_pkg::VSQ_PW;
  localparam int HI = vsq_pkg::VSQ_HI_LSB;
  localparam int LO = vsq_pkg::VSQ_LO_LSB;

  vsq_core_if cfg();

  logic [PW-1:0] line_pixel_length;
  logic [2:0] blanking_alternation_enable;
  vsq_pkg::vsq_mask_type output_mask_select;
  logic [NCH-1:0] toggle_group_choice;
  logic join_on;
  logic [1:0] group_a_alternation_field;
  logic alt_on;
  logic restart;
  logic hold1_en;
  logic hold2_en;
  logic [PW-1:0] hold1_pos;
  logic [PW-1:0] restart1_pos;
  logic [PW-1:0] hold2_pos;
  logic [PW-1:0] restart2_pos;
  logic [PW-1:0] a_rep [4];
  logic [PW-1:0] rep_sel_a;
  logic [PW-1:0] grp_start [2];
  logic [PW-1:0] grp_len [2];
  logic [PW-1:0] grp_reps [2];
  vsq_pkg::vsq_grp_type grp_st [2];
  logic [PW-1:0] grp_pos [2];
  logic [PW-1:0] grp_cnt [2];
  vsq_pkg::vsq_run_type run_st;
  logic held;
  logic [NCH-1:0] lvl_a;
  logic [NCH-1:0] lvl_b;
  logic [NCH-1:0] lvl;
  logic [PW-1:0] tog [vsq_pkg::VSQ_NTOG];
  logic [vsq_pkg::VSQ_NTOG-1:0] tog_hit;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // Register port and shadow storage
  assign cfg.wr_en = reg_wr_i;
  assign cfg.rd_en = reg_rd_i;
  assign cfg.wr_addr = reg_addr_i;
  assign cfg.rd_addr = reg_addr_i;
  assign cfg.wr_data = reg_data_i;
  assign cfg.commit = sequence_change_boundary_i;
  assign reg_rdata_o = cfg.rd_data;

  vsq_param_store #(.NREG(vsq_pkg::VSQ_NREG)) u_store (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .st(cfg.store)
  );

  vsq_line_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tm(cfg.timer)
  );

  // Active field decode
  assign line_pixel_length =
    cfg.word[vsq_pkg::VSQ_LINE_REG][HI +: PW];
  assign cfg.line_len = line_pixel_length;
  assign output_mask_select = vsq_pkg::vsq_mask_type'(
    cfg.word[vsq_pkg::VSQ_LINE_REG][vsq_pkg::VSQ_MASK_LSB +: 2]);
  assign blanking_alternation_enable =
    cfg.word[vsq_pkg::VSQ_LINE_REG][vsq_pkg::VSQ_ALT_LSB +: vsq_pkg::VSQ_ALTW];
  assign alt_on = |blanking_alternation_enable;
  assign toggle_group_choice =
    cfg.word[vsq_pkg::VSQ_GSEL_REG][LO +: NCH];
  assign join_on =
    cfg.word[vsq_pkg::VSQ_GSEL_REG][vsq_pkg::VSQ_JOIN_BIT];
  assign group_a_alternation_field =
    cfg.word[vsq_pkg::VSQ_GSEL_REG][vsq_pkg::VSQ_AMODE_LSB +: 2];
  assign cfg.alt_mode = group_a_alternation_field;
  assign group_b_pattern_choice_o = cfg.word[vsq_pkg::VSQ_GSEL_REG]
    [vsq_pkg::VSQ_PATB_LSB +: vsq_pkg::VSQ_SELW];
  assign group_a_pattern_choice_o = cfg.word[vsq_pkg::VSQ_GSEL_REG]
    [vsq_pkg::VSQ_PATA_LSB +: vsq_pkg::VSQ_SELW];
  assign hold1_pos = cfg.word[vsq_pkg::VSQ_HOLD1_REG][LO +: PW];
  assign restart1_pos = cfg.word[vsq_pkg::VSQ_HOLD1_REG][HI +: PW];
  assign hold2_pos = cfg.word[vsq_pkg::VSQ_HOLD2_REG][LO +: PW];
  assign restart2_pos = cfg.word[vsq_pkg::VSQ_HOLD2_REG][HI +: PW];
  assign line_odd_o = cfg.line_odd;

  // Group start, length and counts; index 0 is A, 1 is B
  assign grp_start[0] = cfg.word[vsq_pkg::VSQ_A_POS_REG][LO +: PW];
  assign grp_len[0] = cfg.word[vsq_pkg::VSQ_A_POS_REG][HI +: PW];
  assign grp_start[1] = cfg.word[vsq_pkg::VSQ_B_POS_REG][LO +: PW];
  assign grp_len[1] = cfg.word[vsq_pkg::VSQ_B_POS_REG][HI +: PW];
  assign a_rep[0] = {1'b0,
    cfg.word[vsq_pkg::VSQ_A_REP12_REG][LO +: vsq_pkg::VSQ_REPW]};
  assign a_rep[1] = {1'b0,
    cfg.word[vsq_pkg::VSQ_A_REP12_REG][HI +: vsq_pkg::VSQ_REPW]};
  assign a_rep[2] = cfg.word[vsq_pkg::VSQ_A_REP34_REG][LO +: PW];
  assign a_rep[3] = cfg.word[vsq_pkg::VSQ_A_REP34_REG][HI +: PW];

  // Under blanking alternation the third and fourth counts are toggle
  // positions, so lines three and four fall back to the first two counts
  always_comb begin
    unique case (cfg.phase)
      2'h0: rep_sel_a = a_rep[0];
      2'h1: rep_sel_a = a_rep[1];
      2'h2: rep_sel_a = alt_on ? a_rep[0] : a_rep[2];
      2'h3: rep_sel_a = alt_on ? a_rep[1] : a_rep[3];
    endcase
  end
  assign grp_reps[0] = rep_sel_a;
  assign grp_reps[1] = {1'b0, cfg.line_odd
    ? cfg.word[vsq_pkg::VSQ_B_REP_REG][LO +: vsq_pkg::VSQ_REPW]
    : cfg.word[vsq_pkg::VSQ_B_REP_REG][HI +: vsq_pkg::VSQ_REPW]};

  amode_zero_a: assert property (
    group_a_alternation_field == 2'h0 |-> rep_sel_a == a_rep[0])
    else $error("group A count not the first count with alternation off");

  assign restart = sequence_change_boundary_i | cfg.line_last;

  // Group sequencers: wait for start, play len pixels reps times
  for (genvar g = 0; g < 2; g++) begin : g_grp
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        grp_st[g] <= vsq_pkg::VSQ_WAIT;
        grp_pos[g] <= '0;
        grp_cnt[g] <= '0;
      end else if (restart) begin
        grp_st[g] <= vsq_pkg::VSQ_WAIT;
        grp_pos[g] <= '0;
        grp_cnt[g] <= '0;
      end else begin
        unique case (grp_st[g])
          vsq_pkg::VSQ_WAIT: begin
            if (cfg.pix == grp_start[g] && grp_len[g] != '0 &&
                grp_reps[g] != '0) begin
              grp_st[g] <= vsq_pkg::VSQ_PLAY;
            end
          end
          vsq_pkg::VSQ_PLAY: begin
            // A hold stalls the pattern so it finishes after restart
            if (!held) begin
              if (grp_pos[g] == grp_len[g] - vsq_pkg::VSQ_ONE_POS) begin
                grp_pos[g] <= '0;
                if (grp_cnt[g] >= grp_reps[g] - vsq_pkg::VSQ_ONE_POS) begin
                  grp_st[g] <= vsq_pkg::VSQ_DONE;
                end else begin
                  grp_cnt[g] <= grp_cnt[g] + vsq_pkg::VSQ_ONE_POS;
                end
              end else begin
                grp_pos[g] <= grp_pos[g] + vsq_pkg::VSQ_ONE_POS;
              end
            end
          end
          vsq_pkg::VSQ_DONE: begin
          end
          default: grp_st[g] <= vsq_pkg::VSQ_WAIT;
        endcase
      end
    end

    grp_begin_a: assert property (
      (grp_st[g] == vsq_pkg::VSQ_WAIT && !restart &&
       cfg.pix == grp_start[g] && grp_len[g] != '0 && grp_reps[g] != '0)
      |=> grp_st[g] == vsq_pkg::VSQ_PLAY)
      else $error("group did not start at its start position");

    grp_end_a: assert property (
      (grp_st[g] == vsq_pkg::VSQ_PLAY && !restart && !held &&
       grp_pos[g] == grp_len[g] - vsq_pkg::VSQ_ONE_POS &&
       grp_cnt[g] == grp_reps[g] - vsq_pkg::VSQ_ONE_POS)
      |=> grp_st[g] == vsq_pkg::VSQ_DONE)
      else $error("group did not stop after its last repetition");
  end

  assign group_a_pos_o = grp_pos[0];
  assign group_b_pos_o = grp_pos[1];

  // Hold and restart; toggle-position reuse disables the pairs
  assign hold1_en = !alt_on && (output_mask_select == vsq_pkg::VSQ_MASK_FIRST
    || output_mask_select == vsq_pkg::VSQ_MASK_BOTH);
  assign hold2_en = !alt_on && (output_mask_select == vsq_pkg::VSQ_MASK_SECOND
    || output_mask_select == vsq_pkg::VSQ_MASK_BOTH);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      run_st <= vsq_pkg::VSQ_RUN;
    end else if (restart) begin
      run_st <= vsq_pkg::VSQ_RUN;
    end else begin
      unique case (run_st)
        vsq_pkg::VSQ_RUN: begin
          if (hold1_en && cfg.pix == hold1_pos) begin
            run_st <= vsq_pkg::VSQ_HOLD1;
          end else if (hold2_en && cfg.pix == hold2_pos) begin
            run_st <= vsq_pkg::VSQ_HOLD2;
          end
        end
        vsq_pkg::VSQ_HOLD1: begin
          if (cfg.pix == restart1_pos) begin
            run_st <= vsq_pkg::VSQ_RUN;
          end
        end
        vsq_pkg::VSQ_HOLD2: begin
          if (cfg.pix == restart2_pos) begin
            run_st <= vsq_pkg::VSQ_RUN;
          end
        end
        default: run_st <= vsq_pkg::VSQ_RUN;
      endcase
    end
  end
  assign held = (run_st != vsq_pkg::VSQ_RUN);

  mask_off_a: assert property (
    (run_st == vsq_pkg::VSQ_RUN &&
     output_mask_select == vsq_pkg::VSQ_MASK_OFF)
    |=> run_st == vsq_pkg::VSQ_RUN)
    else $error("hold entered with masking off");

  hold_enter_a: assert property (
    (run_st == vsq_pkg::VSQ_RUN && !restart && !alt_on &&
     output_mask_select[0] && cfg.pix == hold1_pos)
    |=> run_st == vsq_pkg::VSQ_HOLD1)
    else $error("first hold position missed");

  resume_pair_a: assert property (
    (run_st == vsq_pkg::VSQ_HOLD2 && !restart && cfg.pix == restart2_pos)
    |=> run_st == vsq_pkg::VSQ_RUN)
    else $error("second restart position missed");

  // Pattern levels, gated to the pixels where each group plays
  assign lvl_a = pat_a_level_i & {NCH{grp_st[0] == vsq_pkg::VSQ_PLAY}};
  assign lvl_b = pat_b_level_i & {NCH{grp_st[1] == vsq_pkg::VSQ_PLAY}};

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    always_comb begin
      if (join_on) begin
        lvl[c] = lvl_a[c] ^ lvl_b[c];
      end else begin
        lvl[c] = toggle_group_choice[c] ? lvl_b[c] : lvl_a[c];
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      vert_out_o <= '0;
    end else if (!held) begin
      vert_out_o <= lvl;
    end
  end

  hold_keep_a: assert property (
    held |=> vert_out_o == $past(vert_out_o))
    else $error("vertical outputs moved while held");

  group_pick_a: assert property (
    (!held && !join_on && !toggle_group_choice[0])
    |=> vert_out_o[0] == $past(lvl_a[0]))
    else $error("channel did not follow group A");

  join_both_a: assert property (
    (!held && join_on) |=> vert_out_o == $past(lvl_a ^ lvl_b))
    else $error("combined pattern is not both groups");

  // Odd-line blanking toggles from the reused fields; even-line
  // toggles live elsewhere, so even lines stay low here
  assign tog[0] = a_rep[2];
  assign tog[1] = a_rep[3];
  assign tog[2] = hold1_pos;
  assign tog[3] = restart1_pos;
  assign tog[4] = hold2_pos;
  assign tog[5] = restart2_pos;

  for (genvar t = 0; t < vsq_pkg::VSQ_NTOG; t++) begin : g_tog
    assign tog_hit[t] = (cfg.pix == tog[t]);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      horizontal_blanking_o <= 1'b0;
    end else if (restart) begin
      horizontal_blanking_o <= 1'b0;
    end else if (alt_on && cfg.line_odd && (|tog_hit)) begin
      horizontal_blanking_o <= ~horizontal_blanking_o;
    end
  end

  blank_toggle_a: assert property (
    (alt_on && cfg.line_odd && !restart && cfg.pix == a_rep[2])
    |=> horizontal_blanking_o != $past(horizontal_blanking_o))
    else $error("blanking did not toggle at first position");

  blank_idle_a: assert property (
    (!alt_on && !horizontal_blanking_o) |=> !horizontal_blanking_o)
    else $error("blanking moved with alternation off");

  line_wrap_a: assert property (
    (cfg.pix == line_pixel_length - vsq_pkg::VSQ_ONE_POS)
    |=> cfg.pix == '0 && cfg.line_odd != $past(cfg.line_odd) ||
        $past(sequence_change_boundary_i))
    else $error("line did not end at its length");

  shadow_hold_a: assert property (
    !sequence_change_boundary_i |=> $stable(cfg.word))
    else $error("active parameters changed between boundaries");
endmodule
